/* rtl/watchdog_and_reset_cause.sv */
// watchdog timer with timed change protection and the reset-cause flag register
// assumes an apb master on clk_sys, reset sources and the 1 MHz oscillator as async pins
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`include "wdt_cfg.svh"
`default_nettype none
module watchdog_and_reset_cause
    import wdt_pkg::*;
#(
    parameter wdt_count_t BASE_TIMEOUT = `WDT_BASE_TIMEOUT
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // core side, same clock
    input  wire logic        watchdog_restart_instruction,
    // asynchronous pins
    input  wire logic        wdt_osc_clk,
    input  wire logic        always_on_fuse,
    input  wire logic        power_on_reset_evt,
    input  wire logic        brownout_reset_evt,
    input  wire logic        external_reset_evt,
    // outputs
    output logic             wdt_reset_pulse,
    output logic             watchdog_active
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // pin synchronisers: first stage feeds only the second stage
    logic [4:0] pin_meta_reg;
    logic [4:0] pin_sync_reg;
    logic       osc_prev_reg;
    wire  [4:0] pin_raw;
    wire        osc_s;
    wire        level2;
    wire        por_s;
    wire        bor_s;
    wire        ext_s;
    wire        osc_tick;

    assign pin_raw = {wdt_osc_clk, always_on_fuse, external_reset_evt,
                      brownout_reset_evt, power_on_reset_evt};
    assign por_s   = pin_sync_reg[0];
    assign bor_s   = pin_sync_reg[1];
    assign ext_s   = pin_sync_reg[2];
    assign level2  = pin_sync_reg[3];
    assign osc_s   = pin_sync_reg[4];
    // the 1 MHz oscillator is sampled, so each of its rising edges is one tick
    assign osc_tick = osc_s & ~osc_prev_reg;

    // two-flop synchronisers for all asynchronous pins
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_meta_reg <= 5'h00;
            pin_sync_reg <= 5'h00;
            osc_prev_reg <= 1'b0;
        end else begin
            pin_meta_reg <= pin_raw;
            pin_sync_reg <= pin_meta_reg;
            osc_prev_reg <= osc_s;
        end
    end

    // ------------------------------------------------------------------
    // apb decode; registers answer with no wait state
    wire       access_ph;
    wire       setup_rd;
    wire       apb_wr;
    reg_sel_t  sel;
    wire       wr_rcf;
    wire       wr_wdc;

    assign sel = ({paddr[11:2], 2'h0} == `RCF_OFFSET) ? SEL_RCF :
                 ({paddr[11:2], 2'h0} == `WDC_OFFSET) ? SEL_WDC : SEL_NONE;
    assign access_ph = psel & penable;
    assign setup_rd  = psel & ~penable & ~pwrite;
    assign apb_wr    = access_ph & pwrite;
    assign wr_rcf    = apb_wr & (sel == SEL_RCF);
    assign wr_wdc    = apb_wr & (sel == SEL_WDC);
    assign pready    = 1'b1;
    assign pslverr   = access_ph & (sel == SEL_NONE);

    // ------------------------------------------------------------------
    // chip reset sources; the watchdog pulse counts as one of them
    logic wdt_pulse_reg;
    wire  chip_reset_any;
    wire  wdt_expire;

    assign chip_reset_any  = por_s | bor_s | ext_s | wdt_pulse_reg;
    assign wdt_reset_pulse = wdt_pulse_reg;

    // one-cycle reset pulse on expiry; expiry itself is a single-cycle event
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wdt_pulse_reg <= 1'b0;
        end else begin
            wdt_pulse_reg <= wdt_expire;
        end
    end

    // ------------------------------------------------------------------
    // reset-cause flags: set always beats a same-cycle clear
    function automatic logic flag_next(input logic set, input logic clr, input logic cur);
        flag_next = set | (~clr & cur);
    endfunction

    logic [3:0] rcf_reg;
    logic [3:0] rcf_next;
    wire  [3:0] rcf_sw_clr;

    // software clears a flag by writing zero to it; writing one leaves it alone
    assign rcf_sw_clr = {4{wr_rcf}} & ~pwdata[3:0];
    assign rcf_next[`RCF_WD_BIT]  = flag_next(wdt_pulse_reg,
                                    por_s | rcf_sw_clr[`RCF_WD_BIT],
                                    rcf_reg[`RCF_WD_BIT]);
    assign rcf_next[`RCF_BO_BIT]  = flag_next(bor_s,
                                    por_s | rcf_sw_clr[`RCF_BO_BIT],
                                    rcf_reg[`RCF_BO_BIT]);
    assign rcf_next[`RCF_EXT_BIT] = flag_next(ext_s,
                                    por_s | rcf_sw_clr[`RCF_EXT_BIT],
                                    rcf_reg[`RCF_EXT_BIT]);
    assign rcf_next[`RCF_POR_BIT] = flag_next(por_s,
                                    rcf_sw_clr[`RCF_POR_BIT],
                                    rcf_reg[`RCF_POR_BIT]);

    // cause flags survive chip resets, except that power-on clears the watchdog, brown-out and external flags; only the block reset wipes them all
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rcf_reg <= `RCF_RESET;
        end else begin
            rcf_reg <= rcf_next;
        end
    end

    // ------------------------------------------------------------------
    // watchdog control with timed change window
    logic       en_reg;
    logic       en_next;
    prescale_t  ps_reg;
    prescale_t  ps_next;
    logic [2:0] win_cnt_reg;
    logic [2:0] win_cnt_next;
    wire        wr_ce;
    wire        wr_en;
    wire        win_open;
    wire        open_seq;
    wire        commit;
    wire        kill;
    wire        eff_en;

    assign wr_ce    = pwdata[`WDC_CE_BIT];
    assign wr_en    = pwdata[`WDC_EN_BIT];
    assign win_open = (win_cnt_reg != 3'h0);
    // both ones in one write start the window, even if enable is already set
    assign open_seq = wr_wdc & wr_ce & wr_en;
    // second write of the sequence: change enable zero, inside the window
    assign commit   = wr_wdc & win_open & ~wr_ce;
    // enable zero with change enable reading one also disables
    assign kill     = wr_wdc & win_open & wr_ce & ~wr_en;
    // fuse programmed forces the watchdog on whatever the register holds
    assign eff_en   = en_reg | level2;
    assign watchdog_active = eff_en;

    // enable: chip reset leaves it off, so level 1 starts disabled
    assign en_next = chip_reset_any ? 1'b0 :
                     open_seq       ? 1'b1 :
                     commit         ? wr_en :
                     kill           ? 1'b0 :
                     (wr_wdc & wr_en) ? 1'b1 :
                     en_reg;
    // prescale changes only through the timed sequence in either level, or back to WDC_PS_RESET on chip reset
    assign ps_next = chip_reset_any ? `WDC_PS_RESET :
                     commit ? pwdata[`WDC_PS_HI:`WDC_PS_LO] : ps_reg;
    // window counts four cycles then closes by itself; a commit closes it early
    assign win_cnt_next = chip_reset_any ? 3'h0 :
                          open_seq ? `WDC_WINDOW_CYCLES :
                          commit   ? 3'h0 :
                          win_open ? win_cnt_reg - 3'h1 : 3'h0;

    // control registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            en_reg      <= 1'b0;
            ps_reg      <= `WDC_PS_RESET;
            win_cnt_reg <= 3'h0;
        end else begin
            en_reg      <= en_next;
            ps_reg      <= ps_next;
            win_cnt_reg <= win_cnt_next;
        end
    end

    // ------------------------------------------------------------------
    // timeout counter
    wdt_if wif ();

    assign wif.restart  = watchdog_restart_instruction | chip_reset_any;
    assign wif.enable   = eff_en;
    assign wif.tick     = osc_tick;
    assign wif.prescale = ps_reg;
    assign wdt_expire   = wif.expire;

    wdt_counter #(
        .BASE_TIMEOUT (BASE_TIMEOUT)
    ) u_counter (
        .clk_sys (clk_sys),
        .rst     (rst),
        .wif     (wif.counter)
    );

    // ------------------------------------------------------------------
    // read data captured in the setup phase, so it stands through the access phase
    logic [31:0] prdata_reg;
    wire  [31:0] rd_mux;
    wire  [7:0]  wdc_view;

    // reserved bits are wired to zero
    assign wdc_view = {3'h0, win_open, eff_en, ps_reg};
    assign rd_mux   = (sel == SEL_RCF) ? {28'h000_0000, rcf_reg} :
                      (sel == SEL_WDC) ? {24'h00_0000, wdc_view} : 32'h0000_0000;
    assign prdata   = prdata_reg;

    // read data register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata_reg <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // checks
    pulse_one_cycle_a: assert property (wdt_pulse_reg |=> !wdt_pulse_reg)
        else $error("watchdog reset pulse longer than one cycle");
    pulse_from_expiry_a: assert property ($rose(wdt_pulse_reg) |-> $past(wdt_expire))
        else $error("reset pulse without expiry");
    wd_flag_set_a: assert property (wdt_pulse_reg |=> rcf_reg[`RCF_WD_BIT])
        else $error("watchdog cause flag not set");
    bo_flag_set_a: assert property (bor_s |=> rcf_reg[`RCF_BO_BIT])
        else $error("brown-out cause flag not set");
    ext_flag_set_a: assert property (ext_s |=> rcf_reg[`RCF_EXT_BIT])
        else $error("external cause flag not set");
    por_clears_a: assert property (por_s && !bor_s && !ext_s && !wdt_pulse_reg
        |=> rcf_reg[`RCF_POR_BIT] && !rcf_reg[`RCF_EXT_BIT] && !rcf_reg[`RCF_BO_BIT])
        else $error("power-on did not set own flag and clear others");
    por_kept_a: assert property (rcf_reg[`RCF_POR_BIT] && !wr_rcf |=> rcf_reg[`RCF_POR_BIT])
        else $error("power-on flag lost without software write");
    win_length_a: assert property (open_seq && !chip_reset_any ##1
        (!wr_wdc && !chip_reset_any)[*4] |=> !win_open)
        else $error("change window not closed after four cycles");
    // a commit or chip reset inside the window closes it early, so only quiet windows count
    win_opens_a: assert property (open_seq && !chip_reset_any ##1
        (!wr_wdc && !chip_reset_any)[*3] |=> win_open)
        else $error("change window shorter than four cycles");
    no_plain_off_a: assert property (wr_wdc && !wr_en && !win_open && !chip_reset_any
        && eff_en |=> eff_en)
        else $error("watchdog disabled without change window");
    level2_on_a: assert property (level2 |-> watchdog_active)
        else $error("enable reads zero with fuse programmed");
    ps_guard_a: assert property (!commit && !chip_reset_any |=> $stable(ps_reg))
        else $error("prescale changed outside timed sequence");
    rsvd_zero_a: assert property (setup_rd |=> prdata_reg[31:8] == 24'h00_0000
        && ($past(sel) != SEL_RCF || prdata_reg[7:4] == 4'h0))
        else $error("reserved bits read nonzero");

    cover_disable_c: cover property (open_seq ##[1:4] (commit && !wr_en) ##1 !eff_en);
    cover_expiry_c:  cover property (wdt_expire ##1 wdt_pulse_reg);
    cover_level2_c:  cover property (level2 && commit && !wr_en ##1 eff_en);
    cover_late_c:    cover property (open_seq ##5 wr_wdc && !wr_en && eff_en);
endmodule // watchdog_and_reset_cause
`default_nettype wire

/* rtl/wdt_counter.sv */
// timeout counter: counts synchronised watchdog oscillator ticks up to the limit
// assumes ticks are one clk_sys cycle wide and already synchronised
`include "wdt_cfg.svh"
`default_nettype none
module wdt_counter
    import wdt_pkg::*;
#(
    parameter wdt_count_t BASE_TIMEOUT = `WDT_BASE_TIMEOUT
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    wdt_if.counter    wif
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    // timeout doubles with each prescale step
    function automatic wdt_count_t timeout_limit(input prescale_t sel);
        timeout_limit = BASE_TIMEOUT << sel;
    endfunction

    wdt_count_t cnt_reg;
    wdt_count_t cnt_next;
    wire        at_limit;
    wire        hold_zero;

    // a restart or a disabled watchdog forces zero, so a late tick cannot fire
    assign hold_zero   = wif.restart | ~wif.enable;
    assign at_limit    = (cnt_reg == timeout_limit(wif.prescale) - 22'h00_0001);
    assign wif.expire  = ~hold_zero & wif.tick & at_limit;
    assign wif.count   = cnt_reg;
    assign cnt_next    = hold_zero ? '0 :
                         ~wif.tick ? cnt_reg :
                         at_limit  ? '0 : cnt_reg + 22'h00_0001;

    // counter register
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    cnt_restart_a: assert property (wif.restart |=> cnt_reg == '0)
        else $error("counter not zero after restart");
    cnt_hold_zero_a: assert property (!wif.enable |=> cnt_reg == '0)
        else $error("counter moved while watchdog disabled");
    expire_cause_a: assert property (wif.expire |-> wif.enable && wif.tick
        && cnt_reg == timeout_limit(wif.prescale) - 22'h00_0001)
        else $error("expiry without enabled watchdog at limit");
endmodule // wdt_counter
`default_nettype wire

/* shared/wdt_cfg.svh */
// constants for the watchdog and reset-cause block: offsets, bit positions, counts
// assumes a 40 MHz system clock and an apb slave with 12-bit byte addresses
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// register byte offsets on the apb slave
`define RCF_OFFSET        12'h000
`define WDC_OFFSET        12'h004

// reset_cause_flags bit positions
`define RCF_WD_BIT        3
`define RCF_BO_BIT        2
`define RCF_EXT_BIT       1
`define RCF_POR_BIT       0

// watchdog_control bit positions
`define WDC_CE_BIT        4
`define WDC_EN_BIT        3
`define WDC_PS_HI         2
`define WDC_PS_LO         0

// reset values
`define RCF_RESET         4'h0
`define WDC_PS_RESET      3'h0

// change window length in system clock cycles
`define WDC_WINDOW_CYCLES 3'h4

// timeout at prescale code 000, in watchdog oscillator cycles
`define WDT_BASE_TIMEOUT  22'h00_4000
`define WDT_CNT_W         22

`endif

/* shared/wdt_if.sv */
// carrier between the watchdog control logic and the timeout counter
// both ends run on clk_sys; no crossing happens through this interface
`default_nettype none
interface wdt_if;
    import wdt_pkg::*;
    logic       restart;
    logic       enable;
    logic       tick;
    prescale_t  prescale;
    logic       expire;
    wdt_count_t count;
    modport ctrl    (output restart, output enable, output tick, output prescale,
                     input expire, input count);
    modport counter (input restart, input enable, input tick, input prescale,
                     output expire, output count);
endinterface
`default_nettype wire

/* shared/wdt_pkg.sv */
// types shared by the watchdog top level and its timeout counter
// assumes wdt_cfg.svh for the counter width
`include "wdt_cfg.svh"
`default_nettype none
package wdt_pkg;
    typedef logic [2:0]              prescale_t;
    typedef logic [`WDT_CNT_W-1:0]   wdt_count_t;
    typedef enum logic [1:0] {SEL_NONE, SEL_RCF, SEL_WDC} reg_sel_t;
endpackage
`default_nettype wire

/* tb/tb_watchdog_and_reset_cause.sv */
// self-checking bench for the watchdog and reset-cause block, driven over apb
// assumes zero-wait apb slave, osc ticks synchronised inside, small BASE_TIMEOUT
`include "wdt_cfg.svh"
`default_nettype none
module tb_watchdog_and_reset_cause;
    import wdt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam wdt_count_t BASE = 22'h00_0010;
    localparam int         LIMIT = 40000;

    logic        clk_sys;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        restart;
    logic        wdt_osc_clk;
    logic        fuse;
    logic [2:0]  evt_v;
    logic        wdt_reset_pulse;
    logic        watchdog_active;
    logic [2:0]  osc_div;
    logic [31:0] rd_s;
    logic        err_s;
    int          error_cnt;
    int          compares;
    int          cyc_cnt;

    watchdog_and_reset_cause #(.BASE_TIMEOUT(BASE)) dut (
        .clk_sys                      (clk_sys),
        .rst                          (rst),
        .psel                         (psel),
        .penable                      (penable),
        .pwrite                       (pwrite),
        .paddr                        (paddr),
        .pwdata                       (pwdata),
        .prdata                       (prdata),
        .pready                       (pready),
        .pslverr                      (pslverr),
        .watchdog_restart_instruction (restart),
        .wdt_osc_clk                  (wdt_osc_clk),
        .always_on_fuse               (fuse),
        .power_on_reset_evt           (evt_v[0]),
        .brownout_reset_evt           (evt_v[2]),
        .external_reset_evt           (evt_v[1]),
        .wdt_reset_pulse              (wdt_reset_pulse),
        .watchdog_active              (watchdog_active)
    );

    // 40 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // oscillator at clk_sys/8, sped up from 1 MHz so timeouts stay short
    always @(posedge clk_sys) begin
        osc_div     <= osc_div + 3'h1;
        wdt_osc_clk <= osc_div[2];
    end

    // hang guard: a stuck run still ends in the closing report
    always @(posedge clk_sys) begin
        cyc_cnt++;
        if (cyc_cnt == LIMIT) begin
            error_cnt++;
            stop_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd_s    = prdata;
        err_s   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb_xfer(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb_xfer(1'b0, a, 32'h0000_0000);
        check(rd_s, exp);
    endtask

    // reset sources are levels through two flops, so hold them a few cycles
    task automatic pulse_evt(input logic [2:0] v);
        evt_v <= v;
        repeat (4) @(posedge clk_sys);
        evt_v <= 3'h0;
        repeat (6) @(posedge clk_sys);
    endtask

    task automatic stop_test();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        int t;
        int n;
        int c;
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0000_0000; restart = 1'b0; fuse = 1'b0; evt_v = 3'h0;
        osc_div = 3'h0; wdt_osc_clk = 1'b0; error_cnt = 0; compares = 0; cyc_cnt = 0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        // reset state, then read and clear the cause register early
        rd_chk(`RCF_OFFSET, 32'h0000_0000);
        wr(`RCF_OFFSET, 32'h0000_0000);
        rd_chk(`WDC_OFFSET, 32'h0000_0000);
        check(watchdog_active, 1'b0);
        // unmapped word is refused and reads zero
        apb_xfer(1'b0, 12'h008, 32'h0000_0000);
        check(err_s, 1'b1);
        check(rd_s, 32'h0000_0000);
        // each reset source sets its own flag; power-on clears the others
        pulse_evt(3'h1);
        rd_chk(`RCF_OFFSET, 32'h0000_0001);
        pulse_evt(3'h2);
        rd_chk(`RCF_OFFSET, 32'h0000_0003);
        pulse_evt(3'h4);
        rd_chk(`RCF_OFFSET, 32'h0000_0007);
        pulse_evt(3'h1);
        rd_chk(`RCF_OFFSET, 32'h0000_0001);
        wr(`RCF_OFFSET, 32'hFFFF_FFFE);
        rd_chk(`RCF_OFFSET, 32'h0000_0000);
        pulse_evt(3'h6);
        rd_chk(`RCF_OFFSET, 32'h0000_0006);
        wr(`RCF_OFFSET, 32'hFFFF_FFF9); // zeros only in bits 2 and 1
        rd_chk(`RCF_OFFSET, 32'h0000_0000);
        // plain enable works, plain disable is ignored
        wr(`WDC_OFFSET, 32'h0000_0008);
        rd_chk(`WDC_OFFSET, 32'h0000_0008);
        check(watchdog_active, 1'b1);
        wr(`WDC_OFFSET, 32'h0000_0000);
        rd_chk(`WDC_OFFSET, 32'h0000_0008);
        // window opens, then closes by itself
        wr(`WDC_OFFSET, 32'h0000_0018);
        rd_chk(`WDC_OFFSET, 32'h0000_0018);
        repeat (4) @(posedge clk_sys);
        rd_chk(`WDC_OFFSET, 32'h0000_0008);
        // second write committing at the fourth edge is still accepted
        wr(`WDC_OFFSET, 32'h0000_0018);
        @(posedge clk_sys);
        wr(`WDC_OFFSET, 32'h0000_0000);
        rd_chk(`WDC_OFFSET, 32'h0000_0000);
        check(watchdog_active, 1'b0);
        // one cycle later and the window has gone
        wr(`WDC_OFFSET, 32'h0000_0008);
        wr(`WDC_OFFSET, 32'h0000_0018);
        repeat (2) @(posedge clk_sys);
        wr(`WDC_OFFSET, 32'h0000_0000);
        rd_chk(`WDC_OFFSET, 32'h0000_0008);
        // enable zero with change enable one inside the window also disables
        wr(`WDC_OFFSET, 32'h0000_0018);
        wr(`WDC_OFFSET, 32'h0000_0010);
        rd_chk(`WDC_OFFSET, 32'h0000_0000);
        check(watchdog_active, 1'b0);
        // prescale only moves through the sequence; reserved bits stay zero
        wr(`WDC_OFFSET, 32'h0000_00EF);
        rd_chk(`WDC_OFFSET, 32'h0000_0008);
        wr(`WDC_OFFSET, 32'h0000_0018);
        wr(`WDC_OFFSET, 32'h0000_00ED);
        rd_chk(`WDC_OFFSET, 32'h0000_000D);
        wr(`WDC_OFFSET, 32'h0000_0018);
        wr(`WDC_OFFSET, 32'h0000_0000);
        // expiry per prescale code, measured from a restart in mid-count
        for (int p = 0; p < 5; p++) begin
            c = (p == 4) ? 7 : p; // the longest code once, the rest would cost too many cycles
            t = (int'(BASE) << c) * 8;
            wr(`WDC_OFFSET, 32'h0000_0018);
            wr(`WDC_OFFSET, 32'h0000_0008 | c);
            repeat (t / 2) @(posedge clk_sys);
            restart <= 1'b1;
            @(posedge clk_sys);
            restart <= 1'b0;
            n = 0;
            while (wdt_reset_pulse !== 1'b1 && n < 2 * t) begin
                @(posedge clk_sys);
                n++;
            end
            check(n >= t - 16 && n <= t + 16, 1'b1);
            @(posedge clk_sys);
            check(wdt_reset_pulse, 1'b0);
            repeat (6) @(posedge clk_sys);
            rd_chk(`RCF_OFFSET, 32'h0000_0008);
            rd_chk(`WDC_OFFSET, 32'h0000_0000);
            // power-on clears the watchdog flag as well
            if (p == 4) begin
                pulse_evt(3'h1);
                rd_chk(`RCF_OFFSET, 32'h0000_0001);
            end
            wr(`RCF_OFFSET, 32'h0000_0000);
            rd_chk(`RCF_OFFSET, 32'h0000_0000);
        end
        // level 2: always enabled, prescale still needs the sequence
        fuse <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check(watchdog_active, 1'b1);
        rd_chk(`WDC_OFFSET, 32'h0000_0008);
        wr(`WDC_OFFSET, 32'h0000_0018);
        wr(`WDC_OFFSET, 32'h0000_0002);
        rd_chk(`WDC_OFFSET, 32'h0000_000A);
        wr(`WDC_OFFSET, 32'h0000_0018);
        wr(`WDC_OFFSET, 32'h0000_0001);
        rd_chk(`WDC_OFFSET, 32'h0000_0009);
        check(watchdog_active, 1'b1);
        stop_test();
    end
endmodule // tb_watchdog_and_reset_cause
`default_nettype wire
